//--- core/line_iface_defines.svh
// Offsets, field positions, reset values and timing counts of the line status block
// How it works
// R1: CMI invert bit set inverts the CMI code on transmit and receive tips.
// R2: CMI enable bit selects CMI coding on the line; clear gives normal data.
// R3: Four-bit receive level code is reported live, 0 loudest, 15 quietest.
// R4: Live open-circuit bit follows the transmit open-circuit detector.
// R5: Current-limit hit shows live and latched, regardless of limiter enable.
// R6: Live bit-code bit is high only while a valid code is being seen.
// R7: Pattern sync sets after 32 matching bits, clears at six errors in 64.
// R8: Transmit clock lost is flagged after one channel time without a transition.
// R9: Clock, open, limit, carrier and threshold bits latch on both edges.
// R10: Receive carrier loss latches on both edges of the carrier-lost condition.
// R11: Jitter FIFO near-limit event latches and clears when status is read.
// R12: Signaling change latches when any enabled receive channel changes state.
// R13: Timer event fires every update interval counted on receive clock edges.
// R14: Below-threshold sets only after level stays under threshold for 50ms.
// R15: Mask bit n enables status bit n; masks reset to zero.
// R16: Interrupt high while any unmasked status bit set; read clears idle bits.
`ifndef LINE_IFACE_DEFINES_SVH
`define LINE_IFACE_DEFINES_SVH

`define IDX_INFO          12'h011
`define IDX_STATUS        12'h016
`define IDX_MASK          12'h017
`define IDX_CONFIG        12'h020
`define IDX_SIG_ENABLE    12'h021
`define IDX_CMI_CTRL      12'h07b

`define BIT_CMI_INVERT    6
`define BIT_CMI_ENABLE    7
`define BIT_E1_MODE       0
`define BIT_INTERVAL_SEL  1
`define THRESH_LSB        4

`define ST_TX_CLOCK_LOST  0
`define ST_OPEN_CIRCUIT   1
`define ST_CURRENT_LIMIT  2
`define ST_CARRIER_LOST   3
`define ST_JITTER_LIMIT   4
`define ST_SIG_CHANGED    5
`define ST_TIMER          6
`define ST_BELOW_THRESH   7
`define ST_TWO_EDGE_MASK  8'h8f

`define RESET_VALUE       32'h0000_0000

`define CLK_PERIOD_NS     8
`define T1_CHAN_NS        5181
`define E1_CHAN_NS        3906
`define T1_RATE_KHZ       1544
`define E1_RATE_KHZ       2048
`define T1_SHORT_MS       42
`define E1_SHORT_TENTH_MS 625
`define BELOW_HOLD_MS     50

`define SYNC_RUN_BITS     32
`define ERR_WINDOW_BITS   64
`define ERR_LIMIT         6

`endif

//--- core/line_iface_pkg.sv
// Types shared by the line interface status block
package line_iface_pkg;

  typedef struct packed {
    logic [3:0] rx_level_code;
    logic       tx_open_circuit;
    logic       tx_current_limit_hit;
    logic       bitcode_seen;
    logic       rx_carrier_lost;
    logic       line_tx_clock_in;
    logic       rx_clock_in;
    logic       rx_data_in;
    logic       rx_line_tip;
    logic       jitter_fifo_near_limit;
  } pins_t;

  typedef struct packed {
    pins_t       sync1;
    pins_t       sync2;
    pins_t       sync3;
    pins_t       filt;
    logic        awrdy;
    logic        wrdy;
    logic        aw_got;
    logic        w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arrdy;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  cmi_ctrl;
    logic [7:0]  config_bits;
    logic [31:0] sig_en;
    logic [7:0]  status;
    logic [7:0]  mask;
    logic        irq;
    logic [7:0]  cond_prev;
    logic [11:0] txclk_cnt;
    logic        tx_lost;
    logic [23:0] tmr_cnt;
    logic [23:0] below_cnt;
    logic        below;
    logic [14:0] prbs;
    logic [5:0]  run;
    logic [5:0]  bitcnt;
    logic [2:0]  errcnt;
    logic        pattern_sync_live;
    logic        tx_tip;
    logic        rx_tip;
  } state_t;

endpackage

//--- core/line_iface_status_irq.sv
// Line interface status, latched events, interrupt mask and CMI control
`timescale 1ns/1ps
`default_nettype none
`include "line_iface_defines.svh"

module line_iface_status_irq #(
  parameter int T1_LONG_EDGES  = `T1_RATE_KHZ * 1000,
  parameter int T1_SHORT_EDGES = `T1_RATE_KHZ * `T1_SHORT_MS,
  parameter int E1_LONG_EDGES  = `E1_RATE_KHZ * 1000,
  parameter int E1_SHORT_EDGES = `E1_RATE_KHZ * `E1_SHORT_TENTH_MS / 10,
  parameter int BELOW_HOLD_CYC = `BELOW_HOLD_MS * 1000000 / `CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // AXI4-Lite write address and data
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output var  logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output var  logic                  s_axi_wready,
  // AXI4-Lite write response
  output var  logic [1:0]            s_axi_bresp,
  output var  logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output var  logic                  s_axi_arready,
  output var  logic [31:0]           s_axi_rdata,
  output var  logic [1:0]            s_axi_rresp,
  output var  logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Line side pins, asynchronous
  input  wire line_iface_pkg::pins_t line_pins,
  // Same-clock inputs from the framer and coder
  input  wire logic [31:0]           rx_signaling_changed,
  input  wire logic                  tx_cmi_code,
  input  wire logic                  tx_nrz_data,
  // Line and interrupt outputs
  output var  logic                  tx_line_tip,
  output var  logic                  rx_cmi_code,
  output var  logic                  cmi_enable,
  output var  logic                  irq
);
  import line_iface_pkg::*;

  // ************************************************
  // Constants
  // ************************************************
  // Rounded up so a slow but live clock never reads as lost
  localparam logic [11:0] T1_CHAN_CYC =
    12'((`T1_CHAN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
  localparam logic [11:0] E1_CHAN_CYC =
    12'((`E1_CHAN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Whether a byte address falls on the register with the given index
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] idx);
    hit = (addr[11:2] == idx[9:0]) && (idx[11:10] == 2'h0);
  endfunction

  function automatic logic mapped(input logic [11:0] addr);
    mapped = hit(addr, `IDX_INFO) || hit(addr, `IDX_STATUS) ||
             hit(addr, `IDX_MASK) || hit(addr, `IDX_CONFIG) ||
             hit(addr, `IDX_SIG_ENABLE) || hit(addr, `IDX_CMI_CTRL);
  endfunction

  state_t s;
  state_t n;

  logic [7:0]  info;
  logic [7:0]  cond;
  logic [7:0]  set_bits;
  logic [7:0]  clr_bits;
  logic [23:0] tmr_limit;
  logic [11:0] chan_cyc;
  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        do_wr;
  logic        rx_edge;
  logic        expect_bit;
  logic        err_bit;

  // ************************************************
  // Next state
  // ************************************************
  always_comb
  begin
    n = s;
    set_bits = 8'h00;
    clr_bits = 8'h00;

    // Only the second and third stages are looked at past the first
    n.sync1 = line_pins;
    n.sync2 = s.sync1;
    n.sync3 = s.sync2;
    n.filt  = (s.sync2 & s.sync3) | (s.filt & (s.sync2 | s.sync3));

    // Live information byte
    info = {s.pattern_sync_live,                      // [R7]
            s.filt.bitcode_seen,          // [R6]
            s.filt.tx_current_limit_hit,  // [R5]
            s.filt.tx_open_circuit,       // [R4]
            s.filt.rx_level_code};        // [R3]

    // Transmit clock watchdog, one channel time
    chan_cyc = s.config_bits[`BIT_E1_MODE] ? E1_CHAN_CYC : T1_CHAN_CYC;
    if (n.filt.line_tx_clock_in != s.filt.line_tx_clock_in)
    begin
      n.txclk_cnt = 12'h000;
      n.tx_lost   = 1'b0;
    end
    else if (s.txclk_cnt >= chan_cyc - 12'h001)
    begin
      n.tx_lost = 1'b1;  // [R8]
    end
    else
    begin
      n.txclk_cnt = s.txclk_cnt + 12'h001;
    end

    // Level must stay under threshold for the whole hold time
    if (s.filt.rx_level_code > s.config_bits[`THRESH_LSB +: 4])
    begin
      if (s.below_cnt >= 24'(BELOW_HOLD_CYC - 1))
      begin
        n.below = 1'b1;  // [R14]
      end
      else
      begin
        n.below_cnt = s.below_cnt + 24'h000001;
      end
    end
    else
    begin
      n.below_cnt = 24'h000000;
      n.below     = 1'b0;
    end

    // Receive clock rising edge drives timer and pattern checker
    rx_edge = n.filt.rx_clock_in && !s.filt.rx_clock_in;
    if (s.config_bits[`BIT_E1_MODE])
    begin
      tmr_limit = s.config_bits[`BIT_INTERVAL_SEL] ? 24'(E1_SHORT_EDGES)
                                                   : 24'(E1_LONG_EDGES);
    end
    else
    begin
      tmr_limit = s.config_bits[`BIT_INTERVAL_SEL] ? 24'(T1_SHORT_EDGES)
                                                   : 24'(T1_LONG_EDGES);
    end

    // Self-synchronising 2^15-1 reference from received bits
    expect_bit = s.prbs[14] ^ s.prbs[13];
    err_bit    = s.filt.rx_data_in != expect_bit;
    if (rx_edge)
    begin
      if (s.tmr_cnt >= tmr_limit - 24'h000001)
      begin
        n.tmr_cnt = 24'h000000;
        set_bits[`ST_TIMER] = 1'b1;  // [R13]
      end
      else
      begin
        n.tmr_cnt = s.tmr_cnt + 24'h000001;
      end
      n.prbs = {s.prbs[13:0], s.filt.rx_data_in};
      if (!s.pattern_sync_live)
      begin
        if (err_bit)
        begin
          n.run = 6'h00;
        end
        else if (s.run == 6'(`SYNC_RUN_BITS - 1))
        begin
          n.pattern_sync_live  = 1'b1;  // [R7]
          n.run    = 6'h00;
          n.bitcnt = 6'h00;
          n.errcnt = 3'h0;
        end
        else
        begin
          n.run = s.run + 6'h01;
        end
      end
      else
      begin
        n.bitcnt = s.bitcnt + 6'h01;
        if (err_bit)
        begin
          n.errcnt = s.errcnt + 3'h1;
        end
        if (err_bit && s.errcnt == 3'(`ERR_LIMIT - 1))
        begin
          n.pattern_sync_live  = 1'b0;  // [R7]
          n.errcnt = 3'h0;
        end
        else if (s.bitcnt == 6'(`ERR_WINDOW_BITS - 1))
        begin
          n.errcnt = 3'h0;
        end
      end
    end

    // Conditions that latch on both edges
    cond = 8'h00;
    cond[`ST_TX_CLOCK_LOST] = s.tx_lost;
    cond[`ST_OPEN_CIRCUIT]  = s.filt.tx_open_circuit;
    cond[`ST_CURRENT_LIMIT] = s.filt.tx_current_limit_hit;  // [R5]
    cond[`ST_CARRIER_LOST]  = s.filt.rx_carrier_lost;       // [R10]
    cond[`ST_BELOW_THRESH]  = s.below;
    n.cond_prev = cond;
    set_bits = set_bits | ((cond ^ s.cond_prev) & `ST_TWO_EDGE_MASK);  // [R9]
    set_bits[`ST_JITTER_LIMIT] = n.filt.jitter_fifo_near_limit &&
                                 !s.filt.jitter_fifo_near_limit;  // [R11]
    set_bits[`ST_SIG_CHANGED]  = |(rx_signaling_changed & s.sig_en);  // [R12]

    // ************************************************
    // Register bus
    // ************************************************
    aw_take = s_axi_awvalid && s.awrdy;
    w_take  = s_axi_wvalid && s.wrdy;
    ar_take = s_axi_arvalid && s.arrdy;
    if (aw_take)
    begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (w_take)
    begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready)
    begin
      n.bvalid = 1'b0;
    end
    // Applied on the edge of the later take; answer one cycle on
    do_wr = n.aw_got && n.w_got && !s.bvalid;
    if (do_wr)
    begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = mapped(n.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (n.wstrb[0])
      begin
        if (hit(n.awaddr, `IDX_STATUS))
        begin
          clr_bits = clr_bits | n.wdata[7:0];
        end
        if (hit(n.awaddr, `IDX_MASK))
        begin
          n.mask = n.wdata[7:0];  // [R15]
        end
        if (hit(n.awaddr, `IDX_CONFIG))
        begin
          n.config_bits = n.wdata[7:0];
        end
        if (hit(n.awaddr, `IDX_CMI_CTRL))
        begin
          n.cmi_ctrl = n.wdata[7:0] & 8'hc0;
        end
      end
      for (int b = 0; b < 4; b++)
      begin
        if (n.wstrb[b] && hit(n.awaddr, `IDX_SIG_ENABLE))
        begin
          n.sig_en[8*b +: 8] = n.wdata[8*b +: 8];
        end
      end
    end
    n.awrdy = !n.aw_got && !n.bvalid;
    n.wrdy  = !n.w_got && !n.bvalid;

    if (s.rvalid && s_axi_rready)
    begin
      n.rvalid = 1'b0;
    end
    if (ar_take)
    begin
      n.rvalid = 1'b1;
      n.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      n.rdata  = 32'h0000_0000;
      if (hit(s_axi_araddr, `IDX_INFO))
      begin
        n.rdata[7:0] = info;
      end
      if (hit(s_axi_araddr, `IDX_STATUS))
      begin
        n.rdata[7:0] = s.status;
        clr_bits = clr_bits | s.status;  // [R11] [R16]
      end
      if (hit(s_axi_araddr, `IDX_MASK))
      begin
        n.rdata[7:0] = s.mask;
      end
      if (hit(s_axi_araddr, `IDX_CONFIG))
      begin
        n.rdata[7:0] = s.config_bits;
      end
      if (hit(s_axi_araddr, `IDX_SIG_ENABLE))
      begin
        n.rdata = s.sig_en;
      end
      if (hit(s_axi_araddr, `IDX_CMI_CTRL))
      begin
        n.rdata[7:0] = s.cmi_ctrl;
      end
    end
    // One read in flight; the next address waits for the answer
    n.arrdy = !n.rvalid;

    // ************************************************
    // Latched status and interrupt
    // ************************************************
    // A live condition keeps its bit; a new event beats the clear
    clr_bits = clr_bits & ~(cond & `ST_TWO_EDGE_MASK);  // [R16]
    n.status = set_bits | (s.status & ~clr_bits);
    n.irq    = |(n.status & n.mask);  // [R15] [R16]

    // CMI coding on the tips
    if (s.cmi_ctrl[`BIT_CMI_ENABLE])
    begin
      n.tx_tip = tx_cmi_code ^ s.cmi_ctrl[`BIT_CMI_INVERT];       // [R1] [R2]
      n.rx_tip = s.filt.rx_line_tip ^ s.cmi_ctrl[`BIT_CMI_INVERT];  // [R1]
    end
    else
    begin
      n.tx_tip = tx_nrz_data;  // [R2]
      n.rx_tip = s.filt.rx_line_tip;
    end
  end

  // ************************************************
  // State register
  // ************************************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  assign s_axi_awready = s.awrdy;
  assign s_axi_wready  = s.wrdy;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_arready = s.arrdy;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign s_axi_rvalid  = s.rvalid;
  assign tx_line_tip   = s.tx_tip;
  assign rx_cmi_code   = s.rx_tip;
  assign cmi_enable    = s.cmi_ctrl[`BIT_CMI_ENABLE];
  assign irq           = s.irq;

endmodule
`default_nettype wire

//--- dv/line_iface_status_irq_properties.sv
// Port assertions for the line status block
`timescale 1ns/1ps
`default_nettype none
module line_iface_status_irq_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Line and interrupt
  input wire logic        tx_nrz_data,
  input wire logic        tx_line_tip,
  input wire logic        cmi_enable,
  input wire logic        irq
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_b_timing: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
    $stable(s_axi_bresp)) else $error("write answer dropped");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
  chk_r_timing: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid &&
    !s_axi_arready) else $error("read answer late");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata)) else $error("read answer dropped");
  chk_r_err: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  // Past reset guard: the tip register still holds its reset value one edge on
  chk_tip_nrz: assert property ($past(reset_n) && !cmi_enable && $stable(cmi_enable) |->
    tx_line_tip == $past(tx_nrz_data)) else $error("tip not following nrz data");
  chk_irq_reset: assert property ($rose(reset_n) |-> !irq)
    else $error("interrupt high after reset");
  cov_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cov_irq: cover property ($rose(irq));
endmodule
bind line_iface_status_irq line_iface_status_irq_properties line_iface_status_irq_properties_i (
  .clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .tx_nrz_data, .tx_line_tip, .cmi_enable, .irq);
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the line status block
`timescale 1ns/1ps
`default_nettype none
`include "line_iface_defines.svh"
module tb;
  import line_iface_pkg::*;
  localparam logic [11:0] A_INFO = `IDX_INFO * 4;
  localparam logic [11:0] A_ST   = `IDX_STATUS * 4;
  localparam logic [11:0] A_MASK = `IDX_MASK * 4;
  localparam logic [11:0] A_CFG  = `IDX_CONFIG * 4;
  localparam logic [11:0] A_SIG  = `IDX_SIG_ENABLE * 4;
  localparam logic [11:0] A_CMI  = `IDX_CMI_CTRL * 4;
  logic        clk, reset_n;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, sig_chg, rd, v;
  logic [1:0]  bresp, rresp, rs;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        cmi_code, nrz, tip, rx_cmi, cmi_en, irq, txclk_run, err_inj;
  logic [14:0] lfsr;
  logic [2:0]  div;
  logic [3:0]  strb;
  pins_t       pins;
  int          failures, tests_run, cyc, t0;

  // Short counts keep the timer and threshold runs brief
  line_iface_status_irq #(.T1_LONG_EDGES(20), .T1_SHORT_EDGES(10), .E1_LONG_EDGES(20),
    .E1_SHORT_EDGES(10), .BELOW_HOLD_CYC(50)) line_iface_status_irq_i (
    .clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .line_pins(pins), .rx_signaling_changed(sig_chg), .tx_cmi_code(cmi_code),
    .tx_nrz_data(nrz), .tx_line_tip(tip), .rx_cmi_code(rx_cmi), .cmi_enable(cmi_en),
    .irq(irq));

  // ****************
  // Clocks and line traffic
  // ****************
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Receive clock of 8 cycles; data moves on its falling half
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    div <= div + 3'h1;
    if (txclk_run && div[1:0] == 2'h0)
      pins.line_tx_clock_in <= ~pins.line_tx_clock_in;
    pins.rx_clock_in <= !div[2];
    if (div == 3'h4)
    begin
      lfsr <= {lfsr[13:0], lfsr[14] ^ lfsr[13]};
      pins.rx_data_in <= lfsr[14] ^ lfsr[13] ^ err_inj;
    end
  end

  // ****************
  // Tasks
  // ****************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // No cycle count assumed; only the watchdog ends a hung wait
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rg(input logic [11:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic setc(input int k, input logic b);
    case (k)
      1: pins.tx_open_circuit <= b;
      2: pins.tx_current_limit_hit <= b;
      3: pins.rx_carrier_lost <= b;
      default: pins.jitter_fifo_near_limit <= b;
    endcase
  endtask
  task automatic wirq;
    repeat (400)
    begin
      @(posedge clk);
      if (irq === 1'b1) break;
    end
    // An interrupt that never comes counts against the run
    if (irq !== 1'b1) failures++;
  endtask
  // Gap between two timer events, both seen through the interrupt
  task automatic gap(input logic [31:0] cfg, input int exp);
    wr(A_CFG, cfg);
    wr(A_ST, 32'h40);
    w(2);
    wirq;
    t0 = cyc;
    wr(A_ST, 32'h40);
    w(2);
    wirq;
    chk("timer gap", cyc - t0 >= exp - 2 && cyc - t0 <= exp + 2, 32'h1);
  endtask
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #(8 * 20000);
    failures++;
    test_done;
  end

  initial
  begin
    reset_n = 1'b0;
    {awaddr, araddr, wdata, sig_chg} = '0;
    {awvalid, wvalid, bready, arvalid, rready, cmi_code, nrz, err_inj} = '0;
    txclk_run = 1'b1;
    strb = 4'hf;
    pins = '0;
    lfsr = 15'h1;
    div = 3'h0;
    cyc = 0;
    failures = 0;
    tests_run = 0;
    void'($urandom(12));
    w(6);
    reset_n <= 1'b1;
    w(2);
    rg(A_MASK);
    chk("mask reset", rd, 32'h0);
    rg(12'h300);
    chk("unmapped read", rs, 32'h2);
    wr(12'h300, 32'hff);
    chk("unmapped write", rs, 32'h2);
    repeat (3)
    begin
      v = $urandom;
      wr(A_MASK, v);
      rg(A_MASK);
      chk("mask", rd, {24'h0, v[7:0]});
    end
    // Lane 0 off leaves byte registers alone; the enable word honours each lane
    strb <= 4'he;
    wr(A_MASK, ~v);
    strb <= 4'h6;
    wr(A_SIG, 32'hffff_ffff);
    strb <= 4'hf;
    rg(A_MASK);
    chk("mask lane off", rd, {24'h0, v[7:0]});
    rg(A_SIG);
    chk("enable lanes", rd, 32'h00ff_ff00);
    // Level extremes first, then random; writes to the live register must not stick
    for (int i = 0; i < 6; i++)
    begin
      v = $urandom;
      if (i < 2) v[3:0] = {4{i[0]}};
      pins.rx_level_code <= v[3:0];
      pins.tx_open_circuit <= v[4];
      pins.tx_current_limit_hit <= v[5];
      pins.bitcode_seen <= v[6];
      w(6);
      wr(A_INFO, ~v);
      rg(A_INFO);
      chk("info", rd[6:0], v[6:0]);
    end
    pins.rx_level_code <= 4'h0;
    setc(1, 1'b0);
    setc(2, 1'b0);
    w(8);
    for (int k = 1; k < 4; k++)
    begin
      wr(A_MASK, 32'h0);
      wr(A_ST, 32'hff);
      setc(k, 1'b1);
      w(8);
      chk("masked irq", irq, 32'h0);
      wr(A_MASK, 32'h1 << k);
      w(3);
      chk("irq", irq, 32'h1);
      rg(A_ST);
      rg(A_ST);
      chk("held bit", rd[k], 32'h1);
      setc(k, 1'b0);
      w(8);
      rg(A_ST);
      chk("fall bit", rd[k], 32'h1);
      rg(A_ST);
      chk("cleared bit", rd[k], 32'h0);
      w(3);
      chk("irq off", irq, 32'h0);
    end
    wr(A_ST, 32'hff);
    txclk_run <= 1'b0;
    w(550);
    rg(A_ST);
    chk("clock present", rd[0], 32'h0);
    w(150);
    rg(A_ST);
    chk("clock lost", rd[0], 32'h1);
    // Same watchdog with the shorter E1 channel time
    txclk_run <= 1'b1;
    wr(A_CFG, 32'h1);
    w(8);
    wr(A_ST, 32'h1);
    txclk_run <= 1'b0;
    w(420);
    rg(A_ST);
    chk("e1 clock present", rd[0], 32'h0);
    w(150);
    rg(A_ST);
    chk("e1 clock lost", rd[0], 32'h1);
    txclk_run <= 1'b1;
    setc(4, 1'b1);
    w(8);
    rg(A_ST);
    chk("jitter set", rd[4], 32'h1);
    rg(A_ST);
    chk("jitter read clear", rd[4], 32'h0);
    setc(4, 1'b0);
    t0 = $urandom_range(31);
    wr(A_SIG, 32'h1 << t0);
    for (int i = 0; i < 2; i++)
    begin
      wr(A_ST, 32'h20);
      sig_chg <= 32'h1 << ((t0 + 1 - i) % 32);
      @(posedge clk);
      sig_chg <= 32'h0;
      w(2);
      rg(A_ST);
      chk("signal change", rd[5], i);
    end
    wr(A_MASK, 32'h40);
    for (int c = 0; c < 4; c++)
      gap(c, c[1] ? 80 : 160);
    wr(A_MASK, 32'h0);
    wr(A_CFG, 32'h50);
    pins.rx_level_code <= 4'h9;
    wr(A_ST, 32'h80);
    w(20);
    rg(A_ST);
    chk("below early", rd[7], 32'h0);
    w(40);
    rg(A_ST);
    chk("below held", rd[7], 32'h1);
    pins.rx_level_code <= 4'h0;
    rg(A_INFO);
    chk("pattern sync", rd[7], 32'h1);
    err_inj <= 1'b1;
    w(128);
    err_inj <= 1'b0;
    rg(A_INFO);
    chk("sync lost", rd[7], 32'h0);
    w(480);
    rg(A_INFO);
    chk("resync", rd[7], 32'h1);
    for (int c = 0; c < 4; c++)
    begin
      wr(A_CMI, c << 6);
      repeat (3)
      begin
        v = $urandom;
        cmi_code <= v[0];
        nrz <= v[1];
        pins.rx_line_tip <= v[2];
        w(6);
        chk("cmi enable", cmi_en, c[1]);
        chk("tx tip", tip, c[1] ? v[0] ^ c[0] : v[1]);
        chk("rx tip", rx_cmi, v[2] ^ (c[1] & c[0]));
      end
    end
    test_done;
  end
endmodule
`default_nettype wire
